// [logic/cpl_pkg.sv]
// Purpose: Shared constants and types for the macrocell logic block
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes:   Configuration travels as packed structs on plain ports
package cpl_pkg;

  // Array sizes
  localparam int NUM_MC_TOTAL  = 128;
  localparam int MC_PER_BLOCK  = 16;
  localparam int PT_PER_MC     = 5;
  localparam int SW_OUTS       = 40;
  localparam int NUM_CHAINS    = 8;
  localparam int CHAIN_FANIN   = 40;
  localparam int FOLD_FANIN    = 21;
  localparam int OE_PINS       = 2;
  localparam int SIG_W         = 16;
  localparam int DEV_PINS      = 100;
  localparam int EXT_GLOBAL_W  = (NUM_MC_TOTAL - MC_PER_BLOCK) + (DEV_PINS - MC_PER_BLOCK);
  localparam int PT_IDX_W      = 3;
  localparam int OE_IDX_W      = 4;

  // Timing
  localparam int CLK_HZ        = 20000000;
  localparam int CLK_PERIOD_NS = 50;

  // Reset values
  localparam logic       Q_RESET   = 1'b0;
  localparam logic [15:0] SIG_RESET = 16'h0000;

  // Storage element kinds
  typedef enum logic [2:0] {ELEM_D, ELEM_T, ELEM_JK, ELEM_SR, ELEM_LATCH} cpl_elem_t;
  // Storage data source
  typedef enum logic [1:0] {DSRC_XOR, DSRC_PT, DSRC_PIN} cpl_dsrc_t;
  // Clock source
  typedef enum logic {CLK_GLOBAL, CLK_PT} cpl_clksel_t;
  // Asynchronous clear source
  typedef enum logic [1:0] {CLR_GLOBAL, CLR_PT, CLR_OFF, CLR_BOTH} cpl_clr_t;
  // Asynchronous preset source
  typedef enum logic {PRE_PT, PRE_OFF} cpl_pre_t;
  // Pin direction
  typedef enum logic [1:0] {IO_IN, IO_OUT, IO_BIDIR} cpl_io_t;
  // Output enable source
  typedef enum logic [1:0] {OE_PIN0, OE_PIN1, OE_IOPIN, OE_MCELL} cpl_oe_t;

  // Per-macrocell configuration
  typedef struct packed {
    logic [PT_PER_MC-1:0] ptToOr;
    logic                 xorPol;
    logic                 cascEn;
    cpl_dsrc_t            dSrc;
    logic [PT_IDX_W-1:0]  dataPt;
    logic [PT_IDX_W-1:0]  kPt;
    cpl_elem_t            elem;
    cpl_clksel_t          clkSel;
    logic [PT_IDX_W-1:0]  clkPt;
    logic                 ceEn;
    logic [PT_IDX_W-1:0]  cePt;
    cpl_clr_t             clrSel;
    logic [PT_IDX_W-1:0]  clrPt;
    cpl_pre_t             preSel;
    logic [PT_IDX_W-1:0]  prePt;
    logic [PT_IDX_W-1:0]  foldPt;
    logic                 outReg;
    logic                 fbReg;
    cpl_io_t              ioMode;
    cpl_oe_t              oeSrc;
    logic                 oeInv;
    logic [OE_IDX_W-1:0]  oeIdx;
  } cpl_mc_cfg_t;

endpackage : cpl_pkg

// [logic/cpl_storage.sv]
// Purpose: One macrocell storage element (D, T, JK, SR or latch)
// Assumes: Macrocell clock is a sampled level, edges seen on clk
// Notes:   Clear beats preset; both act without a macrocell clock edge
`timescale 1ns/10ps
module cpl_storage (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Element control
  input  wire cpl_pkg::cpl_elem_t elem,
  input  wire logic              dIn,
  input  wire logic              kIn,
  input  wire logic              mcClk,
  input  wire logic              edgeOk,
  input  wire logic              clrIn,
  input  wire logic              preIn,
  // Stored value
  output logic                   q
);
  logic stateR;
  logic clkPrevR;
  logic rise;
  logic stateNxt;

  assign rise = mcClk & ~clkPrevR;

  always_ff @(posedge clk) begin
    if (rst) clkPrevR <= 1'b0;
    else clkPrevR <= mcClk;
  end

  // Next state per element kind
  always_comb begin
    unique case (elem)
      cpl_pkg::ELEM_D:  stateNxt = dIn;
      cpl_pkg::ELEM_T:  stateNxt = stateR ^ dIn;
      cpl_pkg::ELEM_JK: stateNxt = (dIn & ~stateR) | (~kIn & stateR);
      cpl_pkg::ELEM_SR: stateNxt = dIn | (~kIn & stateR);
      default:          stateNxt = dIn;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) stateR <= cpl_pkg::Q_RESET;
    else if (clrIn) stateR <= 1'b0;
    else if (preIn) stateR <= 1'b1;
    else if (elem == cpl_pkg::ELEM_LATCH) begin
      if (mcClk) stateR <= dIn;
    end else if (rise && edgeOk) stateR <= stateNxt;
  end

  assign q = clrIn ? 1'b0 : preIn ? 1'b1 :
             (elem == cpl_pkg::ELEM_LATCH && mcClk) ? dIn : stateR;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence dEdge;
    elem == cpl_pkg::ELEM_D && rise && edgeOk && !clrIn && !preIn;
  endsequence

  chk_clear_wins: assert property (clrIn |-> !q)
    else $error("clear did not force output low");
  chk_latch_pass: assert property (elem == cpl_pkg::ELEM_LATCH && mcClk && !clrIn && !preIn
    |-> q == dIn)
    else $error("latch not transparent while clock high");
  chk_d_capture: assert property (dEdge ##1 (!clrIn && !preIn && elem == cpl_pkg::ELEM_D)
    |-> q == $past(dIn))
    else $error("D element missed rising edge");
  chk_edge_ignored: assert property (elem == cpl_pkg::ELEM_D && !edgeOk && !clrIn && !preIn
    ##1 (!clrIn && !preIn) |-> stateR == $past(stateR))
    else $error("disabled edge changed state");

endmodule : cpl_storage

// [logic/cpl_logic_block.sv]
// Purpose: One logic block of sixteen macrocells with switch matrix
// Assumes: All pin inputs synchronous to clk; config ports held static
// Notes:   Asynchronous clear and preset act on the same cycle at outputs
`timescale 1ns/10ps
module cpl_logic_block #(
  parameter int NMC   = cpl_pkg::MC_PER_BLOCK,
  parameter int NPT   = cpl_pkg::PT_PER_MC,
  parameter int SW    = cpl_pkg::SW_OUTS,
  parameter int EXT_W = cpl_pkg::EXT_GLOBAL_W,
  parameter int GBW   = EXT_W + 2 * NMC,
  parameter int SELW  = $clog2(GBW),
  parameter int PIW   = SW + NMC
) (
  // Clock and reset
  input  wire logic                                clk,
  input  wire logic                                rst,
  // Global control lines
  input  wire logic                                globalClockLine,
  input  wire logic                                globalClearLine,
  input  wire logic [cpl_pkg::OE_PINS-1:0]         oePin,
  // Global bus from the rest of the device
  input  wire logic [EXT_W-1:0]                    extGlobal,
  // Cascade chain
  input  wire logic                                cascIn,
  output logic                                     cascOut,
  // Block pins
  input  wire logic [NMC-1:0]                      pinIn,
  output logic [NMC-1:0]                           pinOut,
  output logic [NMC-1:0]                           pinOe,
  // Buried feedback to the global bus
  output logic [NMC-1:0]                           fbOut,
  // Configuration
  input  wire cpl_pkg::cpl_mc_cfg_t                mcCfg [NMC],
  input  wire logic [NPT-1:0][PIW-1:0]             ptTrue [NMC],
  input  wire logic [NPT-1:0][PIW-1:0]             ptComp [NMC],
  input  wire logic [SELW-1:0]                     swSel [SW],
  // Signature and protection
  input  wire logic [cpl_pkg::SIG_W-1:0]           sigStore,
  input  wire logic                                fuseProg,
  output logic [cpl_pkg::SIG_W-1:0]                sigRead,
  input  wire logic [cpl_pkg::OE_IDX_W-1:0]        cfgRdIdx,
  output cpl_pkg::cpl_mc_cfg_t                     cfgRdData
);

  logic [GBW-1:0]           gbus;
  logic [SW-1:0]            swOut;
  logic [PIW-1:0]           ptIn;
  logic [NMC-1:0]           fold;
  logic [NMC-1:0][NPT-1:0]  pt;
  logic [NMC-1:0][NPT-1:0]  ptOr;
  logic [NMC-1:0]           orSum;
  logic [NMC-1:0]           xorOut;
  logic [NMC-1:0]           q;
  logic [NMC-1:0]           dSel;
  logic [NMC-1:0]           kSel;
  logic [NMC-1:0]           mcClk;
  logic [NMC-1:0]           edgeOk;
  logic [NMC-1:0]           clrA;
  logic [NMC-1:0]           preA;
  logic [NMC-1:0]           oeRaw;

  // Pick one of the macrocell's product terms by index
  function automatic logic ptPick(logic [NPT-1:0] terms, logic [cpl_pkg::PT_IDX_W-1:0] idx);
    logic r;
    r = 1'b0;
    if (int'(idx) < NPT) r = terms[idx];
    return r;
  endfunction : ptPick

  // AND of selected true and complemented inputs
  function automatic logic ptEval(logic [PIW-1:0] inV, logic [PIW-1:0] tM,
                                  logic [PIW-1:0] cM);
    return &(~tM | inV) & &(~cM | ~inV);
  endfunction : ptEval

  // Global bus: external pins and feedbacks, own pins, own feedbacks
  assign gbus = {extGlobal, pinIn, fbOut};

  // Switch matrix
  always_comb begin
    for (int s = 0; s < SW; s++) begin
      swOut[s] = (int'(swSel[s]) < GBW) ? gbus[swSel[s]] : 1'b0;
    end
  end

  // Product-term inputs: regional foldback bus plus switch outputs
  assign ptIn = {fold, swOut};

  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      for (int p = 0; p < NPT; p++) begin
        pt[m][p] = ptEval(ptIn, ptTrue[m][p], ptComp[m][p]);
      end
    end
  end

  // Foldback terms, each an inverted product term
  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      fold[m] = ~ptPick(pt[m], mcCfg[m].foldPt);
    end
  end

  // Sum terms with cascade from the previous macrocell
  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      ptOr[m] = pt[m] & mcCfg[m].ptToOr;
      orSum[m] = |ptOr[m];
      if (mcCfg[m].cascEn) begin
        orSum[m] = orSum[m] | ((m == 0) ? cascIn : orSum[(m == 0) ? 0 : m - 1]);
      end
      xorOut[m] = orSum[m] ^ mcCfg[m].xorPol;
    end
  end

  assign cascOut = orSum[NMC-1];

  // Storage element controls
  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      unique case (mcCfg[m].dSrc)
        cpl_pkg::DSRC_XOR: dSel[m] = xorOut[m];
        cpl_pkg::DSRC_PT:  dSel[m] = ptPick(pt[m], mcCfg[m].dataPt);
        cpl_pkg::DSRC_PIN: dSel[m] = pinIn[m];
        default:           dSel[m] = xorOut[m];
      endcase
      kSel[m] = ptPick(pt[m], mcCfg[m].kPt);
      if (mcCfg[m].clkSel == cpl_pkg::CLK_GLOBAL) begin
        mcClk[m] = globalClockLine;
        edgeOk[m] = !mcCfg[m].ceEn || ptPick(pt[m], mcCfg[m].cePt);
      end else begin
        mcClk[m] = ptPick(pt[m], mcCfg[m].clkPt);
        edgeOk[m] = 1'b1;
      end
      unique case (mcCfg[m].clrSel)
        cpl_pkg::CLR_GLOBAL: clrA[m] = globalClearLine;
        cpl_pkg::CLR_PT:     clrA[m] = ptPick(pt[m], mcCfg[m].clrPt);
        cpl_pkg::CLR_OFF:    clrA[m] = 1'b0;
        cpl_pkg::CLR_BOTH:   clrA[m] = globalClearLine | ptPick(pt[m], mcCfg[m].clrPt);
        default:             clrA[m] = 1'b0;
      endcase
      preA[m] = (mcCfg[m].preSel == cpl_pkg::PRE_PT) ?
                ptPick(pt[m], mcCfg[m].prePt) : 1'b0;
    end
  end

  for (genvar g = 0; g < NMC; g++) begin : gMc
    cpl_storage uStore (
      .clk    (clk),
      .rst    (rst),
      .elem   (mcCfg[g].elem),
      .dIn    (dSel[g]),
      .kIn    (kSel[g]),
      .mcClk  (mcClk[g]),
      .edgeOk (edgeOk[g]),
      .clrIn  (clrA[g]),
      .preIn  (preA[g]),
      .q      (q[g])
    );
  end

  // Pin output and feedback
  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      pinOut[m] = mcCfg[m].outReg ? q[m] : xorOut[m];
      fbOut[m] = mcCfg[m].fbReg ? q[m] : xorOut[m];
    end
  end

  // Output enable; kept apart so any cell's feedback is settled when read
  always_comb begin
    for (int m = 0; m < NMC; m++) begin
      unique case (mcCfg[m].oeSrc)
        cpl_pkg::OE_PIN0:  oeRaw[m] = oePin[0];
        cpl_pkg::OE_PIN1:  oeRaw[m] = oePin[1];
        cpl_pkg::OE_IOPIN: oeRaw[m] = pinIn[mcCfg[m].oeIdx];
        cpl_pkg::OE_MCELL: oeRaw[m] = fbOut[mcCfg[m].oeIdx];
        default:           oeRaw[m] = 1'b0;
      endcase
      unique case (mcCfg[m].ioMode)
        cpl_pkg::IO_IN:    pinOe[m] = 1'b0;
        cpl_pkg::IO_OUT:   pinOe[m] = 1'b1;
        cpl_pkg::IO_BIDIR: pinOe[m] = oeRaw[m] ^ mcCfg[m].oeInv;
        default:           pinOe[m] = 1'b0;
      endcase
    end
  end

  // Signature readback, always available
  always_ff @(posedge clk) begin
    if (rst) sigRead <= cpl_pkg::SIG_RESET;
    else sigRead <= sigStore;
  end

  // Configuration readback, blanked while fuseProg is high
  always_ff @(posedge clk) begin
    if (rst || fuseProg) cfgRdData <= '0;
    else cfgRdData <= mcCfg[cfgRdIdx];
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_sig_read: assert property (##1 sigRead == $past(sigStore))
    else $error("signature readback wrong");
  chk_cfg_lock: assert property (fuseProg |=> cfgRdData == '0)
    else $error("configuration visible with fuse programmed");
  chk_sw_route: assert property (int'(swSel[0]) < GBW |-> swOut[0] == gbus[swSel[0]])
    else $error("switch output does not follow selection");
  chk_casc_out: assert property (mcCfg[NMC-1].cascEn && orSum[NMC-2] |-> cascOut)
    else $error("cascade did not propagate");

  for (genvar c = 0; c < NMC; c++) begin : gChk
    chk_oe_input: assert property (mcCfg[c].ioMode == cpl_pkg::IO_IN |-> !pinOe[c])
      else $error("input-only pin driven");
    chk_out_comb: assert property (!mcCfg[c].outReg |-> pinOut[c] == xorOut[c])
      else $error("combinational output mismatch");
    chk_fb_reg: assert property (mcCfg[c].fbReg |-> fbOut[c] == q[c])
      else $error("registered feedback mismatch");
    chk_fold_inv: assert property (int'(mcCfg[c].foldPt) < NPT
      |-> fold[c] == !pt[c][mcCfg[c].foldPt])
      else $error("foldback not inverted term");
    chk_clr_off: assert property (mcCfg[c].clrSel == cpl_pkg::CLR_OFF |-> !clrA[c])
      else $error("clear active while disabled");
    chk_pre_off: assert property (mcCfg[c].preSel == cpl_pkg::PRE_OFF |-> !preA[c])
      else $error("preset active while disabled");
    chk_ce_gate: assert property (mcCfg[c].clkSel == cpl_pkg::CLK_PT |-> edgeOk[c])
      else $error("enable applied to term clock");
  end

endmodule : cpl_logic_block

// [sim/cpl_board.sv]
// Purpose: Board model that drives and reads the block pins
// Assumes: Pins have no pull resistors
// Notes:   A pin nobody drives shows the inverse of the board value
`timescale 1ns/10ps
module cpl_board (
  // Block pins
  input  wire logic [15:0] pinOut,
  input  wire logic [15:0] pinOe,
  output logic      [15:0] pinIn,
  // Board side
  input  wire logic [15:0] boardVal,
  input  wire logic [15:0] boardEn
);
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pinIn[i] = pinOe[i] ? pinOut[i] : (boardEn[i] ? boardVal[i] : ~boardVal[i]);
    end
  end
endmodule : cpl_board

// [sim/tb_cpl_logic_block.sv]
// Purpose: Self-checking bench for one logic block
// Assumes: Config held static between drives, inputs move 2 ns after clk
// Notes:   Product term p reads extGlobal bit p alone, except term 0 of macrocell 2 in tRoute, which reads foldback 3
`timescale 1ns/10ps
module tb_cpl_logic_block;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 global_clock_line = 1'b0;
  logic                 gclr = 1'b0;
  logic                 fuse = 1'b0;
  logic [1:0]           oePin = 2'h3;
  logic [195:0]         ext = '0;
  logic [15:0]          pinIn, pinOut, pinOe, fbOut, sigRead;
  logic [15:0]          bVal = 16'h0000;
  logic [15:0]          sigStore = 16'h0000;
  logic [3:0]           rdIdx = 4'h0;
  logic                 cascIn = 1'b0;
  logic                 cascOut;
  cpl_pkg::cpl_mc_cfg_t cfg [16];
  cpl_pkg::cpl_mc_cfg_t rdData;
  logic [4:0][55:0]     ptT [16];
  logic [4:0][55:0]     ptC [16];
  logic [7:0]           swSel [40];
  int                   nFail = 0;
  int                   samplesChecked = 0;

  always #25 clk = ~clk;

  cpl_logic_block uut (.clk(clk), .rst(rst), .globalClockLine(global_clock_line), .globalClearLine(gclr),
    .oePin(oePin), .extGlobal(ext), .cascIn(cascIn), .cascOut(cascOut), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .fbOut(fbOut), .mcCfg(cfg), .ptTrue(ptT), .ptComp(ptC),
    .swSel(swSel), .sigStore(sigStore), .fuseProg(fuse), .sigRead(sigRead),
    .cfgRdIdx(rdIdx), .cfgRdData(rdData));
  cpl_board brd (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn), .boardVal(bVal),
    .boardEn(16'hFFFF));

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step

  task automatic chkVec(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chkVec

  task automatic chkCfg(input cpl_pkg::cpl_mc_cfg_t exp, input cpl_pkg::cpl_mc_cfg_t got);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected cfgRdData exp %h got %h", exp, got);
    end
  endtask : chkCfg

  task automatic pulse();
    global_clock_line = 1'b1;
    step(1);
    global_clock_line = 1'b0;
    step(3);
  endtask : pulse

  function automatic cpl_pkg::cpl_mc_cfg_t dflt();
    cpl_pkg::cpl_mc_cfg_t c;
    c = '0;
    c.dSrc = cpl_pkg::DSRC_PT;
    c.kPt = 3'h1;
    c.cePt = 3'h2;
    c.clrPt = 3'h3;
    c.prePt = 3'h4;
    c.clrSel = cpl_pkg::CLR_OFF;
    c.preSel = cpl_pkg::PRE_OFF;
    c.outReg = 1'b1;
    c.fbReg = 1'b1;
    c.ioMode = cpl_pkg::IO_OUT;
    return c;
  endfunction : dflt

  // Sources product term, XOR and pin; kinds D, T, JK, SR
  task automatic tFlops();
    cfg[0].dSrc = cpl_pkg::DSRC_XOR;
    cfg[0].ptToOr = 5'h01;
    cfg[1].dSrc = cpl_pkg::DSRC_PIN;
    cfg[1].ioMode = cpl_pkg::IO_IN;
    cfg[3].elem = cpl_pkg::ELEM_T;
    cfg[4].elem = cpl_pkg::ELEM_JK;
    cfg[5].elem = cpl_pkg::ELEM_SR;
    ext[1:0] = 2'h1;
    bVal[1] = 1'b1;
    step(3);
    chkVec("fbNoEdge", 16'h0000, fbOut);
    pulse();
    chkVec("fbSet", 16'hFFFF, fbOut);
    chkVec("inOnlyOe", 16'h0000, {15'h0, pinOe[1]});
    ext[1:0] = 2'h2;
    bVal[1] = 1'b0;
    pulse();
    chkVec("fbReset", 16'h0008, fbOut);
    chkVec("pinReg", 16'h0000, {15'h0, pinOut[0]});
    $display("done flops");
  endtask : tFlops

  // Clock enable and product-term clock
  task automatic tClkEn();
    for (int m = 0; m < 16; m++) cfg[m].ceEn = 1'b1;
    cfg[6].ceEn = 1'b0;
    cfg[6].clkSel = cpl_pkg::CLK_PT;
    cfg[6].clkPt = 3'h3;
    ext[2:0] = 3'h1;
    pulse();
    chkVec("ceLow", 16'h0008, fbOut);
    ext[2] = 1'b1;
    pulse();
    chkVec("ceHigh", 16'hFFB5, fbOut);
    ext[3] = 1'b1;
    step(3);
    chkVec("ptClock", 16'hFFF5, fbOut);
    ext[3] = 1'b0;
    $display("done clock enable");
  endtask : tClkEn

  // Every clear source, preset, clear against preset
  task automatic tClear();
    logic cl;
    for (int m = 0; m < 4; m++) begin
      cfg[0].clrSel = cpl_pkg::cpl_clr_t'(2'(m));
      cfg[0].preSel = cpl_pkg::PRE_PT;
      for (int s = 0; s < 2; s++) begin
        ext[4] = 1'b1;
        step(2);
        ext[4] = 1'b0;
        gclr = (s == 0);
        ext[3] = (s == 1);
        step(2);
        cl = (s == 1) ? (m == 1 || m == 3) : (m == 0 || m == 3);
        chkVec("clrMode", {15'h0, ~cl}, {15'h0, fbOut[0]});
        gclr = 1'b0;
        ext[3] = 1'b0;
      end
    end
    ext[4:3] = 2'h3;
    step(2);
    chkVec("clrWins", 16'h0000, {15'h0, fbOut[0]});
    ext[4:3] = 2'h0;
    $display("done clear");
  endtask : tClear

  task automatic tLatch();
    cfg[0] = dflt();
    cfg[0].elem = cpl_pkg::ELEM_LATCH;
    global_clock_line = 1'b1;
    ext[0] = 1'b1;
    step(2);
    chkVec("latchPass", 16'h0001, {15'h0, fbOut[0]});
    global_clock_line = 1'b0;
    step(2);
    ext[0] = 1'b0;
    step(2);
    chkVec("latchHold", 16'h0001, {15'h0, fbOut[0]});
    $display("done latch");
  endtask : tLatch

  // Five-term sum; output and feedback forms apart
  task automatic tOr();
    cfg[0] = dflt();
    cfg[0].dSrc = cpl_pkg::DSRC_XOR;
    cfg[0].ptToOr = 5'h1F;
    cfg[0].outReg = 1'b0;
    for (int k = 0; k < 5; k++) begin
      ext[4:0] = 5'h01 << k;
      step(1);
      chkVec("orTerm", 16'h0001, {15'h0, pinOut[0]});
    end
    ext[4:0] = 5'h00;
    step(1);
    chkVec("orNone", 16'h0002, {15'h0, fbOut[0], pinOut[0]});
    cfg[0].outReg = 1'b1;
    cfg[0].fbReg = 1'b0;
    step(1);
    chkVec("fbComb", 16'h0001, {15'h0, fbOut[0], pinOut[0]});
    $display("done sum");
  endtask : tOr

  task automatic tOe();
    cfg[0].ioMode = cpl_pkg::IO_BIDIR;
    for (int i = 0; i < 16; i++) begin
      cfg[0].oeSrc = i[3] ? cpl_pkg::OE_PIN1 : cpl_pkg::OE_PIN0;
      cfg[0].oeInv = i[2];
      oePin = i[1:0];
      step(1);
      chkVec("pinOe", {15'h0, oePin[i[3]] ^ i[2]}, {15'h0, pinOe[0]});
    end
    cfg[0].oeSrc = cpl_pkg::OE_IOPIN;
    cfg[0].oeIdx = 4'h1;
    cfg[0].oeInv = 1'b0;
    bVal[1] = 1'b1;
    step(1);
    chkVec("oeIoPin", 16'h0001, {15'h0, pinOe[0]});
    cfg[0].oeSrc = cpl_pkg::OE_MCELL;
    cfg[0].oeIdx = 4'h0;
    ext[0] = 1'b1;
    step(1);
    chkVec("oeMcellHigh", 16'h0001, {15'h0, pinOe[0]});
    ext[0] = 1'b0;
    step(1);
    chkVec("oeMcellLow", 16'h0000, {15'h0, pinOe[0]});
    $display("done enable");
  endtask : tOe

  task automatic tSig();
    sigStore = 16'hA5C3;
    fuse = 1'b1;
    rdIdx = 4'h5;
    step(2);
    chkVec("sigRead", 16'hA5C3, sigRead);
    chkCfg('0, rdData);
    fuse = 1'b0;
    step(2);
    chkCfg(cfg[5], rdData);
    $display("done signature");
  endtask : tSig

  // Cascade through every cell; foldback read back as an inverted term
  task automatic tRoute();
    for (int m = 0; m < 16; m++) begin
      cfg[m] = dflt();
      cfg[m].cascEn = 1'b1;
    end
    ext[4:0] = 5'h00;
    cascIn = 1'b1;
    step(1);
    chkVec("cascIn", 16'h0001, {15'h0, cascOut});
    cascIn = 1'b0;
    step(1);
    chkVec("cascIdle", 16'h0000, {15'h0, cascOut});
    cfg[7].ptToOr = 5'h01;
    ext[0] = 1'b1;
    step(1);
    chkVec("cascMid", 16'h0001, {15'h0, cascOut});
    cfg[2].cascEn = 1'b0;
    cfg[2].ptToOr = 5'h01;
    cfg[2].outReg = 1'b0;
    ptT[2][0] = 56'h1 << 43;
    step(1);
    chkVec("foldHigh", 16'h0000, {15'h0, pinOut[2]});
    ext[0] = 1'b0;
    step(1);
    chkVec("foldLow", 16'h0001, {15'h0, pinOut[2]});
    $display("done routing");
  endtask : tRoute

  task automatic closeOut();
    $display("checks %0d mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : closeOut

  initial begin
    for (int m = 0; m < 16; m++) begin
      cfg[m] = dflt();
      for (int p = 0; p < 5; p++) begin
        ptT[m][p] = 56'h1 << (p + 1);
        ptC[m][p] = '0;
      end
    end
    for (int k = 0; k < 40; k++) swSel[k] = (k > 0 && k < 6) ? 8'h1F + 8'(k) : 8'hFF;
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    step(1);
    chkVec("fbAfterReset", 16'h0000, fbOut);
    chkVec("sigAfterReset", 16'h0000, sigRead);
    tFlops();
    tClkEn();
    tClear();
    tLatch();
    tOr();
    tOe();
    tSig();
    tRoute();
    closeOut();
  end

  initial begin
    repeat (4000) @(posedge clk);
    nFail++;
    $display("unexpected timeout");
    closeOut();
  end
endmodule : tb_cpl_logic_block
